// ===== hdl/tws_pkg.sv
// shared constants, types and state layouts for the two-wire slave block
package tws_pkg;

    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_OWN = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;

    // bit positions in two_wire_control
    localparam int CTL_FLAG = 7;
    localparam int CTL_ACK = 6;
    localparam int CTL_STA = 5;
    localparam int CTL_STO = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_EN = 2;
    localparam int CTL_IE = 0;

    // values after reset
    localparam logic [7:0] RST_OWN = 8'h00;
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [7:0] RST_STATUS = 8'hF8;
    localparam logic [1:0] RST_LINE = 2'h3;

    // bits in a byte on the wire, and the prescaler mask of the status word
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] PRESCALE_MASK = 8'h03;

    // status codes
    localparam logic [7:0] ST_SR_OWN = 8'h60;
    localparam logic [7:0] ST_SR_OWN_ARB = 8'h68;
    localparam logic [7:0] ST_SR_GC = 8'h70;
    localparam logic [7:0] ST_SR_GC_ARB = 8'h78;
    localparam logic [7:0] ST_SR_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
    localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
    localparam logic [7:0] ST_SR_STOP = 8'hA0;
    localparam logic [7:0] ST_ST_OWN = 8'hA8;
    localparam logic [7:0] ST_ST_OWN_ARB = 8'hB0;
    localparam logic [7:0] ST_ST_DATA_ACK = 8'hB8;
    localparam logic [7:0] ST_ST_DATA_NACK = 8'hC0;
    localparam logic [7:0] ST_ST_LAST_ACK = 8'hC8;

    // bus-side sequencer states
    typedef enum logic [2:0] {
        TWS_IDLE = 3'b000,
        TWS_ADDR = 3'b001,
        TWS_ADDR_ACK = 3'b010,
        TWS_RX_DATA = 3'b011,
        TWS_RX_ACK = 3'b100,
        TWS_TX_DATA = 3'b101,
        TWS_TX_ACK = 3'b110,
        TWS_IGNORE = 3'b111
    } tws_state_e;

    // apb request and response
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tws_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tws_apb_rsp_s;

    // wire levels seen, and drive of the open-drain lines
    typedef struct packed {
        logic scl;
        logic sda;
    } tws_line_s;

    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } tws_drive_s;

    // input filter state
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] level;
    } tws_sync_s;

    // all state of the slave core
    typedef struct packed {
        tws_state_e st;
        logic [7:0] own_addr;
        logic [7:0] data;
        logic [7:0] status;
        logic flag;
        logic ack_en;
        logic start_req;
        logic stop_req;
        logic wcol;
        logic if_en;
        logic irq_en;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic rw;
        logic gc;
        logic acked;
        logic last_byte;
        logic busy;
        logic start_pend;
        logic start_go;
        logic wake;
        logic scl_prev;
        logic sda_prev;
        logic sda_drive;
        logic scl_hold;
        logic [31:0] prdata;
    } tws_core_s;

endpackage : tws_pkg

// ===== hdl/tws_sync.sv
// three-stage input filter for the scl and sda wire levels
`timescale 1ns/1ps
module tws_sync (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // raw wire levels and filtered levels
    input wire logic [1:0] raw,
    output logic [1:0] level
);

    tws_pkg::tws_sync_s r;
    tws_pkg::tws_sync_s n;

    // a level change counts only once the second and third stages agree
    always_comb begin
        n = r;
        n.s1 = raw;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.level = (r.s2 & r.s3) | (r.level & (r.s2 ^ r.s3));
    end

    // idle bus reads high, so every stage resets high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{s1: tws_pkg::RST_LINE, s2: tws_pkg::RST_LINE,
                   s3: tws_pkg::RST_LINE, level: tws_pkg::RST_LINE};
        end else begin
            r <= n;
        end
    end

    assign level = r.level;

endmodule : tws_sync

// ===== hdl/tws_slave.sv
// two-wire slave receiver and transmitter with apb registers
//
// Functional notes
// - respond only when upper seven own-address bits equal the received address
// - own-address lsb one enables general call response, zero ignores it
// - after match, direction bit one selects transmit, zero selects receive
// - after address and direction, set the flag and a valid status
// - status codes assume prescaler bits read as zero
// - lost arbitration then addressed for read reports status B0
// - ack enable cleared: send one last byte, then C0 on nack, C8 on ack
// - after last byte go not addressed and release data, master reads ones
// - ack enable zero ignores own address but keeps watching the bus
// - in deep sleep with ack enabled, recognise and ack address and wake part
// - after address wake-up hold scl low until flag is cleared
// - after address wake-up the data register need not hold the bus byte
// - status 90: next byte received, acked per ack enable
// - status 98: go not addressed, recognition follows ack and general-call enables
// - status A0 on stop or repeated start while addressed, then not addressed; the code sets A0 only in TWS_RX_DATA and TWS_RX_ACK
// - flag cleared with start request while not addressed sends start when bus free
`timescale 1ns/1ps
module tws_slave (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // apb register port
    input wire tws_pkg::tws_apb_req_s APB_REQ,
    output tws_pkg::tws_apb_rsp_s APB_RSP,
    // two-wire lines, open drain
    input wire tws_pkg::tws_line_s LINE_IN,
    output tws_pkg::tws_drive_s LINE_DRV,
    // system side
    input wire logic ARB_LOST,
    input wire logic DEEP_SLEEP,
    output logic WAKE_REQ,
    output logic BUS_START
);

    tws_pkg::tws_core_s r;
    tws_pkg::tws_core_s n;
    logic [1:0] line_lvl;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic apb_setup;
    logic apb_wr;
    logic clr_evt;
    logic addr_done;

    // true for any mapped register address
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == tws_pkg::ADDR_OWN) || (a == tws_pkg::ADDR_CTRL) ||
               (a == tws_pkg::ADDR_STAT) || (a == tws_pkg::ADDR_DATA);
    endfunction : is_mapped

    // address byte hits own address or an enabled general call
    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] own);
        return (b[7:1] == own[7:1]) || ((b[7:1] == 7'h00) && own[0]);
    endfunction : addr_hit

    // states in which the block is the addressed slave
    function automatic logic addressed(input tws_pkg::tws_state_e s);
        return (s == tws_pkg::TWS_ADDR_ACK) || (s == tws_pkg::TWS_RX_DATA) ||
               (s == tws_pkg::TWS_RX_ACK) || (s == tws_pkg::TWS_TX_DATA) ||
               (s == tws_pkg::TWS_TX_ACK);
    endfunction : addressed

    // wire levels come from another domain, so they are filtered first
    tws_sync u_sync (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .raw({LINE_IN.scl, LINE_IN.sda}),
        .level(line_lvl)
    );

    // edges and bus conditions from the filtered levels
    assign scl = line_lvl[1];
    assign sda = line_lvl[0];
    assign scl_rise = scl && !r.scl_prev;
    assign scl_fall = !scl && r.scl_prev;
    assign start_det = scl && r.scl_prev && r.sda_prev && !sda;
    assign stop_det = scl && r.scl_prev && !r.sda_prev && sda;
    assign addr_done = (r.st == tws_pkg::TWS_ADDR) && scl_fall && (r.cnt == tws_pkg::BYTE_BITS);

    // apb decode; writes land only in the access phase
    assign apb_setup = APB_REQ.psel && !APB_REQ.penable;
    assign apb_wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && is_mapped(APB_REQ.paddr);
    assign clr_evt = apb_wr && (APB_REQ.paddr == tws_pkg::ADDR_CTRL) &&
                     APB_REQ.pwdata[tws_pkg::CTL_FLAG];

    // next-state logic for registers and the bus sequencer
    always_comb begin
        logic set_flag;
        logic match;
        set_flag = 1'b0;
        match = 1'b0;
        n = r;
        n.start_go = 1'b0;
        n.scl_prev = scl;
        n.sda_prev = sda;

        // read data is captured in the setup phase so it is a flop in the access phase
        if (apb_setup && !APB_REQ.pwrite) begin
            case (APB_REQ.paddr)
                tws_pkg::ADDR_OWN: n.prdata = {24'h000000, r.own_addr};
                tws_pkg::ADDR_CTRL: n.prdata = {24'h000000, r.flag, r.ack_en, r.start_req,
                                                r.stop_req, r.wcol, r.if_en, 1'b0, r.irq_en};
                tws_pkg::ADDR_STAT: n.prdata = {24'h000000, r.status & ~tws_pkg::PRESCALE_MASK};
                tws_pkg::ADDR_DATA: n.prdata = {24'h000000, r.data};
                default: n.prdata = 32'h00000000;
            endcase
        end

        // software writes
        if (apb_wr) begin
            case (APB_REQ.paddr)
                tws_pkg::ADDR_OWN: n.own_addr = APB_REQ.pwdata[7:0];
                tws_pkg::ADDR_CTRL: begin
                    n.ack_en = APB_REQ.pwdata[tws_pkg::CTL_ACK];
                    n.start_req = APB_REQ.pwdata[tws_pkg::CTL_STA];
                    n.stop_req = APB_REQ.pwdata[tws_pkg::CTL_STO];
                    n.if_en = APB_REQ.pwdata[tws_pkg::CTL_EN];
                    n.irq_en = APB_REQ.pwdata[tws_pkg::CTL_IE];
                end
                tws_pkg::ADDR_DATA: begin
                    // loading data while the bus is moving is a collision
                    if (r.flag) begin
                        n.data = APB_REQ.pwdata[7:0];
                        n.wcol = 1'b0;
                    end else begin
                        n.wcol = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // writing one to the flag releases the bus
        if (clr_evt) begin
            n.flag = 1'b0;
            n.wake = 1'b0;
            if (r.st == tws_pkg::TWS_TX_DATA) begin
                n.shift = n.data;
                n.cnt = 4'h0;
                n.sda_drive = !n.data[7];
                n.last_byte = !APB_REQ.pwdata[tws_pkg::CTL_ACK];
            end
            if (!addressed(r.st) && APB_REQ.pwdata[tws_pkg::CTL_STA]) begin
                n.start_pend = 1'b1;
            end
        end

        // bus sequencer
        if (!r.if_en) begin
            n.st = tws_pkg::TWS_IDLE;
            n.sda_drive = 1'b0;
            n.busy = 1'b0;
        end else if (start_det || stop_det) begin
            // a stop or repeated start ends any addressed receive
            if ((r.st == tws_pkg::TWS_RX_DATA) || (r.st == tws_pkg::TWS_RX_ACK)) begin
                set_flag = 1'b1;
                n.status = tws_pkg::ST_SR_STOP;
            end
            n.st = start_det ? tws_pkg::TWS_ADDR : tws_pkg::TWS_IDLE;
            n.busy = start_det;
            n.cnt = 4'h0;
            n.sda_drive = 1'b0;
        end else begin
            unique case (r.st)
                tws_pkg::TWS_IDLE, tws_pkg::TWS_IGNORE: ;
                tws_pkg::TWS_ADDR: begin
                    if (scl_rise) begin
                        n.shift = {r.shift[6:0], sda};
                        n.cnt = r.cnt + 4'h1;
                    end else if (addr_done) begin
                        // no answer while ack is off or a status is still pending
                        match = addr_hit(r.shift, r.own_addr) && r.ack_en && !r.flag;
                        if (match) begin
                            n.sda_drive = 1'b1;
                            n.rw = r.shift[0];
                            n.gc = (r.shift[7:1] == 7'h00);
                            n.wake = DEEP_SLEEP;
                            n.st = tws_pkg::TWS_ADDR_ACK;
                        end else begin
                            n.st = tws_pkg::TWS_IGNORE;
                        end
                    end
                end
                tws_pkg::TWS_ADDR_ACK: begin
                    if (scl_fall) begin
                        n.sda_drive = 1'b0;
                        n.cnt = 4'h0;
                        set_flag = 1'b1;
                        if (r.rw) begin
                            n.st = tws_pkg::TWS_TX_DATA;
                            n.status = ARB_LOST ? tws_pkg::ST_ST_OWN_ARB : tws_pkg::ST_ST_OWN;
                        end else begin
                            n.st = tws_pkg::TWS_RX_DATA;
                            if (r.gc) begin
                                n.status = ARB_LOST ? tws_pkg::ST_SR_GC_ARB : tws_pkg::ST_SR_GC;
                            end else begin
                                n.status = ARB_LOST ? tws_pkg::ST_SR_OWN_ARB : tws_pkg::ST_SR_OWN;
                            end
                        end
                    end
                end
                tws_pkg::TWS_RX_DATA: begin
                    if (scl_rise && !r.flag) begin
                        n.shift = {r.shift[6:0], sda};
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && (r.cnt == tws_pkg::BYTE_BITS)) begin
                        // bytes seen while asleep are not kept
                        if (!DEEP_SLEEP) begin
                            n.data = r.shift;
                        end
                        n.acked = r.ack_en;
                        n.sda_drive = r.ack_en;
                        n.st = tws_pkg::TWS_RX_ACK;
                    end
                end
                tws_pkg::TWS_RX_ACK: begin
                    if (scl_fall) begin
                        n.sda_drive = 1'b0;
                        n.cnt = 4'h0;
                        set_flag = 1'b1;
                        if (r.gc) begin
                            n.status = r.acked ? tws_pkg::ST_GC_DATA_ACK : tws_pkg::ST_GC_DATA_NACK;
                        end else begin
                            n.status = r.acked ? tws_pkg::ST_SR_DATA_ACK : tws_pkg::ST_SR_DATA_NACK;
                        end
                        n.st = r.acked ? tws_pkg::TWS_RX_DATA : tws_pkg::TWS_IGNORE;
                    end
                end
                tws_pkg::TWS_TX_DATA: begin
                    if (scl_rise && !r.flag) begin
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && !r.flag && (r.cnt == tws_pkg::BYTE_BITS)) begin
                        n.sda_drive = 1'b0;
                        n.st = tws_pkg::TWS_TX_ACK;
                    end else if (scl_fall && !r.flag && (r.cnt != 4'h0)) begin
                        n.shift = {r.shift[6:0], 1'b1};
                        n.sda_drive = !r.shift[6];
                    end
                end
                tws_pkg::TWS_TX_ACK: begin
                    if (scl_rise) begin
                        n.acked = !sda;
                    end else if (scl_fall) begin
                        set_flag = 1'b1;
                        n.cnt = 4'h0;
                        // after the last byte the data line stays released
                        if (!r.acked) begin
                            n.status = tws_pkg::ST_ST_DATA_NACK;
                            n.st = tws_pkg::TWS_IGNORE;
                        end else if (r.last_byte) begin
                            n.status = tws_pkg::ST_ST_LAST_ACK;
                            n.st = tws_pkg::TWS_IGNORE;
                        end else begin
                            n.status = tws_pkg::ST_ST_DATA_ACK;
                            n.st = tws_pkg::TWS_TX_DATA;
                        end
                    end
                end
            endcase
        end

        // a hardware set wins over a clear in the same cycle
        if (set_flag) begin
            n.flag = 1'b1;
        end

        // start request waits for a free bus
        if (r.start_pend && !r.busy) begin
            n.start_go = 1'b1;
            n.start_pend = 1'b0;
            n.start_req = 1'b0;
        end

        // stretching holds the whole bus, including after a wake-up
        n.scl_hold = n.flag && addressed(n.st);
    end

    // single state register
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= '0;
            r.st <= tws_pkg::TWS_IDLE;
            r.own_addr <= tws_pkg::RST_OWN;
            r.data <= tws_pkg::RST_DATA;
            r.status <= tws_pkg::RST_STATUS;
            r.scl_prev <= 1'b1;
            r.sda_prev <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs; the lines are only ever pulled low
    assign APB_RSP.prdata = r.prdata;
    assign APB_RSP.pready = 1'b1;
    assign APB_RSP.pslverr = APB_REQ.psel && APB_REQ.penable && !is_mapped(APB_REQ.paddr);
    assign LINE_DRV.scl_out = 1'b0;
    assign LINE_DRV.scl_oe = r.scl_hold;
    assign LINE_DRV.sda_out = 1'b0;
    assign LINE_DRV.sda_oe = r.sda_drive;
    assign WAKE_REQ = r.wake;
    assign BUS_START = r.start_go;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    // address recognition
    a_own_match: assert property (addr_done && (r.shift[7:1] == r.own_addr[7:1]) && r.ack_en && !r.flag && r.if_en |=> (r.st == tws_pkg::TWS_ADDR_ACK) && r.sda_drive)
        else $error("own address not acknowledged");
    a_gc_ignore: assert property (addr_done && (r.shift[7:1] == 7'h00) && !r.own_addr[0] && (r.own_addr[7:1] != 7'h00) |=> !r.sda_drive)
        else $error("general call acked while disabled");
    a_ack_off: assert property (addr_done && !r.ack_en && r.if_en |=> (r.st == tws_pkg::TWS_IGNORE) && !r.sda_drive)
        else $error("address acked with ack enable low");

    // mode entry and status after the address
    a_mode_select: assert property ((r.st == tws_pkg::TWS_ADDR_ACK) && scl_fall && r.if_en && !start_det && !stop_det |=> r.flag && (r.st == (r.rw ? tws_pkg::TWS_TX_DATA : tws_pkg::TWS_RX_DATA)))
        else $error("wrong mode after address");
    a_flag_status: assert property ($rose(r.flag) |-> (r.status[7:3] != 5'h1F))
        else $error("flag raised without a status");
    a_prescale_zero: assert property (APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite && (APB_REQ.paddr == tws_pkg::ADDR_STAT) |-> (APB_RSP.prdata[1:0] == 2'h0))
        else $error("prescaler bits not zero");
    a_arb_read: assert property ((r.st == tws_pkg::TWS_ADDR_ACK) && scl_fall && r.rw && ARB_LOST && r.if_en && !start_det && !stop_det |=> (r.status == tws_pkg::ST_ST_OWN_ARB))
        else $error("lost arbitration read not B0");

    // transmitter end of transfer
    a_last_ack: assert property ((r.st == tws_pkg::TWS_TX_ACK) && scl_fall && r.acked && r.last_byte && r.if_en && !start_det && !stop_det |=> (r.status == tws_pkg::ST_ST_LAST_ACK) && (r.st == tws_pkg::TWS_IGNORE))
        else $error("last byte acked but no C8");
    a_release_sda: assert property ((r.st == tws_pkg::TWS_IGNORE) [*2] |-> !LINE_DRV.sda_oe)
        else $error("data line driven while not addressed");

    // receiver status after general-call data and stop, and the pending start on a free bus
    a_gc_ack: assert property ((r.st == tws_pkg::TWS_RX_ACK) && scl_fall && r.gc && r.acked && r.if_en && !start_det && !stop_det |=> (r.status == tws_pkg::ST_GC_DATA_ACK) && (r.st == tws_pkg::TWS_RX_DATA))
        else $error("general call data ack not 90");
    a_gc_nack: assert property ((r.st == tws_pkg::TWS_RX_ACK) && scl_fall && r.gc && !r.acked && r.if_en && !start_det && !stop_det |=> (r.status == tws_pkg::ST_GC_DATA_NACK) && !addressed(r.st))
        else $error("general call data nack not 98");
    a_stop_seen: assert property ((r.st == tws_pkg::TWS_RX_DATA) && stop_det && r.if_en |=> (r.status == tws_pkg::ST_SR_STOP) && (r.st == tws_pkg::TWS_IDLE) && r.flag)
        else $error("stop while addressed not A0");
    a_start_free: assert property (r.start_pend && !r.busy |=> BUS_START ##1 !BUS_START)
        else $error("pending start not issued on free bus");

    // sleep wake-up and clock stretch
    a_wake_hold: assert property ($rose(r.wake) |-> ##[1:300] (r.scl_hold || !r.wake || !r.if_en))
        else $error("wake-up without scl hold");
    a_sleep_data: assert property (DEEP_SLEEP && (r.st == tws_pkg::TWS_RX_DATA) && scl_fall && (r.cnt == tws_pkg::BYTE_BITS) |=> (r.data == $past(r.data)))
        else $error("data register loaded while asleep");
    a_stretch: assert property (r.flag && addressed(r.st) |-> LINE_DRV.scl_oe && !scl_rise)
        else $error("scl not stretched while flag set");

    // main scenarios
    c_tx_read: cover property (r.status == tws_pkg::ST_ST_OWN ##[1:1000] r.status == tws_pkg::ST_ST_DATA_ACK);
    c_gc_rx: cover property (r.status == tws_pkg::ST_SR_GC ##[1:1000] r.status == tws_pkg::ST_GC_DATA_ACK);
    c_last_c8: cover property (r.status == tws_pkg::ST_ST_LAST_ACK);
    c_start_go: cover property (BUS_START);

endmodule : tws_slave

// ===== testbench/tws_bus_master.sv
// two-wire bus master model pulling scl and sda through open-drain drivers
`timescale 1ns/1ps
module tws_bus_master (
    // clock and resolved wire levels
    input wire logic clk,
    input wire tws_pkg::tws_line_s line,
    // open-drain pulls, high pulls low, and hang report
    output logic scl_low,
    output logic sda_low,
    output logic hung
);
    // lines released at time zero, so the pull-ups set them high
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hung = 1'b0;
    end
    // one 160 ns bit cell; sda moves only while scl is low, a stretch is waited out with a bound
    task automatic put(input logic b, output logic r);
        int n;
        @(posedge clk);
        sda_low <= ~b;
        repeat (11) @(posedge clk);
        scl_low <= 1'b0;
        n = 0;
        do @(posedge clk); while (line.scl !== 1'b1 && ++n < 20000);
        if (n >= 20000) hung <= 1'b1;
        repeat (19) @(posedge clk);
        r = line.sda;
        scl_low <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : put
    // eight bits msb first plus the ack cell
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) put(o[k], i[k]);
    endtask : xfer
    // start and stop; stop assumes nobody stretches scl
    task automatic start();
        @(posedge clk);
        sda_low <= 1'b1;
        repeat (20) @(posedge clk);
        scl_low <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : start
    task automatic stop();
        @(posedge clk);
        sda_low <= 1'b1;
        repeat (20) @(posedge clk);
        scl_low <= 1'b0;
        repeat (20) @(posedge clk);
        sda_low <= 1'b0;
        repeat (20) @(posedge clk);
    endtask : stop
endmodule : tws_bus_master

// ===== testbench/test_two_wire_slave_tx_rx_status.sv
// self-checking bench: registers over apb, traffic from the bus master model
`timescale 1ns/1ps
module test_two_wire_slave_tx_rx_status;
    logic clk, arst_n, arb_lost, deep_sleep, hung, m_scl, m_sda, wake, bus_start, err;
    logic [8:0] rx;
    logic [31:0] rd;
    int errors = 0;
    int cmp_count = 0;
    tws_pkg::tws_apb_req_s req;
    tws_pkg::tws_apb_rsp_s rsp;
    tws_pkg::tws_line_s line;
    tws_pkg::tws_drive_s drv;
    // wires with pull-ups: low while any party pulls
    assign line.scl = ~(m_scl | (drv.scl_oe & ~drv.scl_out));
    assign line.sda = ~(m_sda | (drv.sda_oe & ~drv.sda_out));
    tws_slave i_dut (.REF_CLK(clk), .ARST_N(arst_n), .APB_REQ(req), .APB_RSP(rsp),
        .LINE_IN(line), .LINE_DRV(drv), .ARB_LOST(arb_lost), .DEEP_SLEEP(deep_sleep),
        .WAKE_REQ(wake), .BUS_START(bus_start));
    tws_bus_master i_mst (.clk(clk), .line(line), .scl_low(m_scl), .sda_low(m_sda), .hung(hung));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bit1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : bit1
    // one apb transfer; the request holds until pready is seen, bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do @(posedge clk); while (rsp.pready !== 1'b1 && ++n < 100);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (n >= 100) begin
            errors++;
            stop_test();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rdc
    // a stuck scl ends the run
    always @(posedge hung) begin
        errors++;
        stop_test();
    end
    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // reset, registers, receive, general call, read, start request and wake-up
    initial begin
        int n;
        req = '0;
        {arb_lost, deep_sleep, arst_n} = 3'h0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        rdc(8'h08, 8'hF8);
        rdc(8'h0C, 8'hFF);
        bit1(err, 1'b0);
        rdc(8'h10, 8'h00);
        bit1(err, 1'b1);
        apb(1'b1, 8'h00, 8'h55);
        apb(1'b1, 8'h04, 8'h44);
        i_mst.start();
        i_mst.xfer(9'h0AD, rx);
        bit1(rx[0], 1'b1);
        i_mst.stop();
        i_mst.start();
        i_mst.xfer(9'h0A9, rx);
        bit1(rx[0], 1'b0);
        rdc(8'h08, 8'h60);
        bit1(drv.scl_oe, 1'b1);
        apb(1'b1, 8'h04, 8'hC4);
        i_mst.xfer(9'h0B5, rx);
        rdc(8'h0C, 8'h5A);
        apb(1'b1, 8'h04, 8'hC4);
        i_mst.stop();
        rdc(8'h08, 8'hA0);
        apb(1'b1, 8'h04, 8'hC4);
        i_mst.start();
        i_mst.xfer(9'h001, rx);
        rdc(8'h08, 8'h70);
        apb(1'b1, 8'h04, 8'hC4);
        i_mst.xfer(9'h067, rx);
        rdc(8'h08, 8'h90);
        apb(1'b1, 8'h04, 8'h84);
        i_mst.xfer(9'h089, rx);
        bit1(rx[0], 1'b1);
        rdc(8'h08, 8'h98);
        i_mst.stop();
        apb(1'b1, 8'h04, 8'h84);
        i_mst.start();
        i_mst.xfer(9'h0A9, rx);
        bit1(rx[0], 1'b1);
        i_mst.stop();
        apb(1'b1, 8'h04, 8'hC4);
        arb_lost <= 1'b1;
        i_mst.start();
        i_mst.xfer(9'h0AB, rx);
        rdc(8'h08, 8'hB0);
        arb_lost <= 1'b0;
        apb(1'b1, 8'h0C, 8'hA5);
        apb(1'b1, 8'h04, 8'h84);
        i_mst.xfer(9'h1FE, rx);
        chk({24'h0, rx[8:1]}, 32'hA5);
        rdc(8'h08, 8'hC8);
        i_mst.xfer(9'h1FE, rx);
        chk({24'h0, rx[8:1]}, 32'hFF);
        i_mst.stop();
        apb(1'b1, 8'h04, 8'hE4);
        for (n = 0; n < 400 && bus_start !== 1'b1; n++) @(posedge clk);
        bit1(n < 400, 1'b1);
        deep_sleep <= 1'b1;
        i_mst.start();
        i_mst.xfer(9'h0A9, rx);
        bit1(wake & drv.scl_oe, 1'b1);
        apb(1'b1, 8'h04, 8'hC4);
        repeat (3) @(posedge clk);
        bit1(wake | drv.scl_oe, 1'b0);
        i_mst.xfer(9'h067, rx);
        rdc(8'h0C, 8'hA5);
        stop_test();
    end
endmodule : test_two_wire_slave_tx_rx_status
